// ---- src/ccb_regs.svh ----
`ifndef CCB_REGS_SVH
`define CCB_REGS_SVH
`define CCB_RESET_VECTOR      20'hFFFF0
`define CCB_NMI_VECTOR_TYPE   8'h02
`define CCB_UPPER_ADDR_LSB    16
`define CCB_UPPER_ADDR_MSB    19
`define CCB_POWERDOWN_TIMER_PIN_LIMIT_DEF   16'h0100
`endif

// ---- src/ccb_pkg.sv ----
package ccb_pkg;
	typedef enum logic [2:0] {
		CCB_IDLE  = 3'b000,
		CCB_ADDR  = 3'b001,
		CCB_DATA  = 3'b010,
		CCB_HOLD  = 3'b011,
		CCB_WAKE  = 3'b100
	} ccb_bus_state_t;
endpackage

// ---- src/ccb_clkdiv.sv ----
// ----------------------------------------
// output clock divider on the link clock
// ----------------------------------------
module ccb_clkdiv (
	input  wire logic clk_in,
	input  wire logic rst_n,
	output logic      clk_half
);
	logic next_clk_half;

	// toggle on every falling edge gives exactly half rate, 50% duty
	always_comb begin
		next_clk_half = ~clk_half;
	end

	always_ff @(negedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			clk_half <= 1'b0;
		end else begin
			clk_half <= next_clk_half;
		end
	end
endmodule // ccb_clkdiv

// ---- src/ccb_core.sv ----
// What this block does
// - output clock is half the input clock
// - 50% duty, toggles on input falling edge
// - reset aborts bus cycle, defined pin states
// - after reset, align clock, fetch at 0FFFF0H
// - reset output active while reset input active
// - wait powerdown timer before resuming
// - nmi edge requests interrupt type 2
// - nmi request held in internal latch
// - wait instruction stalls until test low
// - address phase drives low address on bus
// - address phase drives address 16-19 upper
// - data phase drives upper address to zero
// - 8-bit variant holds address 8-15 whole cycle
// - top address pin sampled as strap in reset
// - oscillator drive never floats in test mode
// - strap low selects float mode, outputs hi-z
// - strobe address latch during address phase
`include "ccb_regs.svh"
module ccb_core import ccb_pkg::*; #(
	parameter int          BUS_WIDTH   = 16,
	parameter logic [15:0] POWERDOWN_TIMER_PIN_LIMIT = `CCB_POWERDOWN_TIMER_PIN_LIMIT_DEF
) (
	input  wire logic                 mclk,
	input  wire logic                 arst_n,
	input  wire logic                 input_clock_pin,
	output logic                      output_clock_pin,
	output logic                      oscillator_drive_pin,
	input  wire logic                 reset_input_pin_n,
	output logic                      reset_output_pin,
	input  wire logic                 powerdown_timer_pin,
	input  wire logic                 powerdown_req,
	output logic                      powerdown_active,
	input  wire logic                 nmi_pin,
	output logic                      nmi_pending,
	output logic [7:0]                nmi_type,
	input  wire logic                 nmi_ack,
	input  wire logic                 test_pin_n,
	input  wire logic                 wait_exec,
	output logic                      wait_stall,
	input  wire logic                 bus_req,
	input  wire logic [19:0]          bus_addr,
	input  wire logic                 bus_write,
	input  wire logic [15:0]          bus_wdata,
	output logic [15:0]               bus_rdata,
	output logic                      bus_done,
	output logic [19:0]               fetch_addr,
	input  wire logic                 hold_req,
	output logic                      hold_ack,
	input  wire logic [15:0]          muxed_addr_data_bus_in,
	output logic [15:0]               muxed_addr_data_bus_out,
	output logic                      muxed_addr_data_bus_oe,
	input  wire logic [3:0]           upper_address_pins_in,
	output logic [3:0]                upper_address_pins_out,
	output logic                      upper_address_pins_oe,
	output logic [7:0]                addr_high_pins,
	output logic                      addr_high_pins_oe,
	output logic                      addr_latch_strobe,
	output logic                      on_circuit_float_mode
);
	localparam int UB = `CCB_UPPER_ADDR_MSB - `CCB_UPPER_ADDR_LSB;

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [6:0] sync1;
	logic [6:0] sync2;
	logic [6:0] next_sync1;
	logic [6:0] next_sync2;
	logic       div_rst_n1;
	logic       div_rst_n2;
	logic       div_clk;
	logic       div_ok;
	logic       rst_act;
	logic       strap_low;
	logic       nmi_s;
	logic       test_s;
	logic       pdt_s;
	logic       clk_s;

	always_comb begin
		next_sync1 = {div_rst_n2, upper_address_pins_in[UB], input_clock_pin,
			powerdown_timer_pin, test_pin_n, nmi_pin, ~reset_input_pin_n};
		next_sync2 = sync1;
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			// idle levels: reset in, strap high, test high; no false float mode
			sync1 <= 7'h25;
			sync2 <= 7'h25;
		end else begin
			sync1 <= next_sync1;
			sync2 <= next_sync2;
		end
	end

	assign rst_act   = sync2[0];
	assign nmi_s     = sync2[1];
	assign test_s    = sync2[2];
	assign pdt_s     = sync2[3];
	assign clk_s     = sync2[4];
	assign strap_low = ~sync2[5];
	assign div_ok    = sync2[6];

	// ----------------------------------------
	// output clock on the link clock
	// ----------------------------------------
	// divider held while reset is in, so its phase restarts on release
	always_ff @(negedge input_clock_pin or posedge rst_act) begin
		if (rst_act) begin
			div_rst_n1 <= 1'b0;
			div_rst_n2 <= 1'b0;
		end else begin
			div_rst_n1 <= 1'b1;
			div_rst_n2 <= div_rst_n1;
		end
	end

	ccb_clkdiv u_div (
		.clk_in   (input_clock_pin),
		.rst_n    (div_rst_n2),
		.clk_half (div_clk)
	);

	// straight from the divider flop; sampling it with mclk would alias
	assign output_clock_pin = div_clk;

	// ----------------------------------------
	// reset, strap, nmi, test, powerdown
	// ----------------------------------------
	ccb_bus_state_t state;
	ccb_bus_state_t next_state;
	logic           float_mode;
	logic           next_float_mode;
	logic           nmi_prev;
	logic           next_nmi_pending;
	logic [15:0]    pd_cnt;
	logic [15:0]    next_pd_cnt;
	logic           next_powerdown_active;

	always_comb begin
		next_float_mode = float_mode;
		if (rst_act) begin
			next_float_mode = strap_low;
		end
		next_nmi_pending = nmi_pending;
		if (nmi_ack) begin
			next_nmi_pending = 1'b0;
		end
		if (nmi_s && !nmi_prev) begin
			next_nmi_pending = 1'b1;
		end
		next_powerdown_active = powerdown_active;
		next_pd_cnt = pd_cnt;
		if (powerdown_req && state == CCB_IDLE) begin
			next_powerdown_active = 1'b1;
			next_pd_cnt = 16'h0000;
		end else if (powerdown_active && !powerdown_req) begin
			// delay ends when the timer pin charges or the count expires, whichever comes first
			if (pdt_s || pd_cnt == POWERDOWN_TIMER_PIN_LIMIT) begin
				next_powerdown_active = 1'b0;
			end else begin
				next_pd_cnt = pd_cnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			float_mode       <= 1'b0;
			nmi_prev         <= 1'b0;
			nmi_pending      <= 1'b0;
			pd_cnt           <= 16'h0000;
			powerdown_active <= 1'b0;
		end else begin
			float_mode       <= next_float_mode;
			nmi_prev         <= nmi_s;
			nmi_pending      <= next_nmi_pending;
			pd_cnt           <= next_pd_cnt;
			powerdown_active <= next_powerdown_active;
		end
	end

	// ----------------------------------------
	// bus cycle sequencer
	// ----------------------------------------
	logic [19:0] cur_addr;
	logic [19:0] next_cur_addr;
	logic [15:0] next_bus_rdata;
	logic        next_bus_done;
	logic [19:0] next_fetch_addr;

	always_comb begin
		next_state      = state;
		next_cur_addr   = cur_addr;
		next_bus_rdata  = bus_rdata;
		next_bus_done   = 1'b0;
		next_fetch_addr = fetch_addr;
		if (rst_act) begin
			next_state      = CCB_WAKE;
			next_fetch_addr = `CCB_RESET_VECTOR;
		end else begin
			unique case (state)
				CCB_WAKE: begin
					// divider release comes back through the synchroniser
					if (div_ok) begin
						next_state = CCB_IDLE;
					end
				end
				CCB_IDLE: begin
					if (hold_req) begin
						next_state = CCB_HOLD;
					end else if (bus_req && !powerdown_active) begin
						next_state    = CCB_ADDR;
						next_cur_addr = bus_addr;
					end
				end
				CCB_ADDR: begin
					next_state = CCB_DATA;
				end
				CCB_DATA: begin
					next_state     = CCB_IDLE;
					next_bus_done  = 1'b1;
					next_bus_rdata = bus_write ? 16'h0000 : muxed_addr_data_bus_in;
					next_fetch_addr = cur_addr;
				end
				CCB_HOLD: begin
					if (!hold_req) begin
						next_state = CCB_IDLE;
					end
				end
				default: begin
					next_state = CCB_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state      <= CCB_WAKE;
			cur_addr   <= 20'h00000;
			bus_rdata  <= 16'h0000;
			bus_done   <= 1'b0;
			fetch_addr <= `CCB_RESET_VECTOR;
		end else begin
			state      <= next_state;
			cur_addr   <= next_cur_addr;
			bus_rdata  <= next_bus_rdata;
			bus_done   <= next_bus_done;
			fetch_addr <= next_fetch_addr;
		end
	end

	// ----------------------------------------
	// pin drivers, all registered
	// ----------------------------------------
	logic [15:0] n_ad;
	logic        n_ad_oe;
	logic [3:0]  n_up;
	logic        n_up_oe;
	logic [7:0]  n_hi;
	logic        n_hi_oe;
	logic        n_ale;
	logic [15:0] lo_mask;

	always_comb begin
		lo_mask = (BUS_WIDTH == 8) ? 16'h00FF : 16'hFFFF;
		n_ad    = 16'h0000;
		n_ad_oe = 1'b0;
		n_up    = 4'h0;
		n_up_oe = 1'b0;
		n_hi    = 8'h00;
		n_hi_oe = 1'b0;
		n_ale   = 1'b0;
		if (next_state == CCB_ADDR) begin
			n_ad    = next_cur_addr[15:0] & lo_mask;
			n_ad_oe = 1'b1;
			n_up    = next_cur_addr[19:16];
			n_up_oe = 1'b1;
			n_ale   = 1'b1;
		end else if (next_state == CCB_DATA) begin
			n_ad    = bus_wdata & lo_mask;
			n_ad_oe = bus_write;
			n_up    = 4'h0;
			n_up_oe = 1'b1;
		end
		if ((next_state == CCB_ADDR || next_state == CCB_DATA) && BUS_WIDTH == 8) begin
			n_hi    = next_cur_addr[15:8];
			n_hi_oe = 1'b1;
		end
		// hold, reset and float mode all release the bus
		if (next_state == CCB_HOLD || rst_act || float_mode) begin
			n_ad_oe = 1'b0;
			n_up_oe = 1'b0;
			n_hi_oe = 1'b0;
			n_ale   = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			muxed_addr_data_bus_out <= 16'h0000;
			muxed_addr_data_bus_oe  <= 1'b0;
			upper_address_pins_out  <= 4'h0;
			upper_address_pins_oe   <= 1'b0;
			addr_high_pins          <= 8'h00;
			addr_high_pins_oe       <= 1'b0;
			addr_latch_strobe       <= 1'b0;
			reset_output_pin        <= 1'b1;
			on_circuit_float_mode   <= 1'b0;
			hold_ack                <= 1'b0;
			wait_stall              <= 1'b0;
			nmi_type                <= 8'h00;
			oscillator_drive_pin    <= 1'b0;
		end else begin
			muxed_addr_data_bus_out <= n_ad;
			muxed_addr_data_bus_oe  <= n_ad_oe;
			upper_address_pins_out  <= n_up;
			upper_address_pins_oe   <= n_up_oe;
			addr_high_pins          <= n_hi;
			addr_high_pins_oe       <= n_hi_oe;
			addr_latch_strobe       <= n_ale;
			reset_output_pin        <= rst_act;
			on_circuit_float_mode   <= float_mode;
			hold_ack                <= (next_state == CCB_HOLD);
			wait_stall              <= wait_exec && test_s;
			nmi_type                <= next_nmi_pending ? `CCB_NMI_VECTOR_TYPE : 8'h00;
			oscillator_drive_pin    <= ~clk_s;
		end
	end
endmodule // ccb_core

// ---- verif/ccb_props.sv ----
// ----------------------------------------
// pin behaviour checks
// ----------------------------------------
module ccb_props (
	input wire logic        mclk,
	input wire logic        arst_n,
	input wire logic        reset_input_pin_n,
	input wire logic        reset_output_pin,
	input wire logic        addr_latch_strobe,
	input wire logic [19:0] bus_addr,
	input wire logic [15:0] muxed_addr_data_bus_out,
	input wire logic        muxed_addr_data_bus_oe,
	input wire logic [3:0]  upper_address_pins_out,
	input wire logic        upper_address_pins_oe,
	input wire logic        hold_ack,
	input wire logic        on_circuit_float_mode,
	input wire logic        nmi_pending,
	input wire logic [7:0]  nmi_type,
	input wire logic        nmi_ack,
	input wire logic        powerdown_active
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!arst_n);
	// four cycles cover the two-stage synchroniser and the output register
	a_reset_out_held: assert property (!reset_input_pin_n [*4] |-> reset_output_pin)
		else $error("reset output dropped");
	a_strobe_single: assert property (addr_latch_strobe |=> !addr_latch_strobe)
		else $error("strobe too long");
	a_addr_drive: assert property (addr_latch_strobe |-> upper_address_pins_oe
		&& muxed_addr_data_bus_oe && muxed_addr_data_bus_out == bus_addr[15:0]
		&& upper_address_pins_out == bus_addr[19:16])
		else $error("address phase wrong");
	a_upper_zero: assert property (addr_latch_strobe |=> upper_address_pins_out == 4'h0)
		else $error("upper pins not zero");
	a_hold_float: assert property (hold_ack
		|-> !muxed_addr_data_bus_oe && !upper_address_pins_oe)
		else $error("pins driven in hold");
	a_float_hiz: assert property (on_circuit_float_mode
		|-> !muxed_addr_data_bus_oe && !upper_address_pins_oe)
		else $error("pins driven in float mode");
	a_nmi_type_two: assert property (nmi_pending |-> nmi_type == 8'h02)
		else $error("wrong nmi type");
	a_nmi_latched: assert property (nmi_pending && !nmi_ack |=> nmi_pending)
		else $error("nmi request lost");
	a_pd_blocks: assert property (powerdown_active [*2] |-> !addr_latch_strobe)
		else $error("bus cycle in powerdown");
endmodule // ccb_props

// ---- verif/ccb_mem_model.sv ----
// ----------------------------------------
// address latch and memory on the bus
// ----------------------------------------
module ccb_mem_model (
	input  wire logic        mclk,
	input  wire logic        ale,
	input  wire logic [15:0] ad_out,
	input  wire logic        ad_oe,
	input  wire logic [3:0]  up_out,
	input  wire logic        up_oe,
	input  wire logic        strap,
	output logic      [15:0] ad_in,
	output logic      [3:0]  up_in
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] mem [256];
	logic [19:0] lat;
	logic        rd = 1'b0;
	logic [15:0] last = 16'h0000;
	always @(posedge mclk) begin
		rd <= ale;
		if (ale)
			lat <= {up_out, ad_out};
		if (ad_oe)
			last <= ad_out;
		if (rd && ad_oe)
			mem[lat[7:0]] <= ad_out;
	end
	// a released bus holds nothing, so show a value the design cannot rely on
	assign ad_in = ad_oe ? ad_out : (rd ? mem[lat[7:0]] : ~last);
	// weak pull-up; only the strap line is ever pulled low
	assign up_in = up_oe ? up_out : {strap, 3'b111};
endmodule // ccb_mem_model

// ---- verif/tb_top.sv ----
// ----------------------------------------
// bench top
// ----------------------------------------
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic        mclk, arst_n, input_clock_pin, output_clock_pin, oscillator_drive_pin;
	logic        reset_input_pin_n, reset_output_pin, powerdown_timer_pin, powerdown_req;
	logic        powerdown_active, nmi_pin, nmi_pending, nmi_ack, test_pin_n, wait_exec;
	logic        wait_stall, bus_req, bus_write, bus_done, hold_req, hold_ack, strap;
	logic        muxed_addr_data_bus_oe, upper_address_pins_oe, addr_latch_strobe;
	logic        on_circuit_float_mode, addr_high_pins_oe;
	logic [7:0]  nmi_type, addr_high_pins;
	logic [19:0] bus_addr, fetch_addr, a;
	logic [15:0] bus_wdata, bus_rdata, d;
	logic [15:0] muxed_addr_data_bus_in, muxed_addr_data_bus_out;
	logic [3:0]  upper_address_pins_in, upper_address_pins_out;
	logic [15:0] mem_m [int];
	logic [19:0] q [$];
	int          seed = 96017, bad_count = 0, checks = 0, oc = 0, ic = 0, o0, i0;

	ccb_core #(.POWERDOWN_TIMER_PIN_LIMIT(16'h0010)) uut (.*);
	ccb_mem_model mem (.mclk, .ale(addr_latch_strobe), .ad_out(muxed_addr_data_bus_out),
		.ad_oe(muxed_addr_data_bus_oe), .up_out(upper_address_pins_out),
		.up_oe(upper_address_pins_oe), .strap, .ad_in(muxed_addr_data_bus_in),
		.up_in(upper_address_pins_in));

	initial begin
		mclk = 0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		input_clock_pin = 0;
		#1.3;
		forever #3 input_clock_pin = ~input_clock_pin;
	end
	always @(negedge input_clock_pin) ic++;
	always @(posedge output_clock_pin) oc++;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// request is dropped in the done cycle so the idle slot does not start another
	task automatic xfer(input logic w, input logic [19:0] ad, input logic [15:0] wd);
		int n;
		n = 0;
		bus_req = 1;
		bus_write = w;
		bus_addr = ad;
		bus_wdata = wd;
		do begin
			cyc(1);
			n++;
		end while (bus_done !== 1'b1 && n < 20);
		chk(bus_done, 1);
		chk(addr_high_pins_oe, 0);
		if (!w)
			chk(bus_rdata, mem_m[ad[7:0]]);
		bus_req = 0;
		cyc(2);
	endtask
	task end_sim;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		{arst_n, reset_input_pin_n, powerdown_timer_pin, powerdown_req, nmi_pin} = 0;
		{nmi_ack, wait_exec, bus_req, bus_write, hold_req} = 0;
		{test_pin_n, strap} = 2'b11;
		bus_addr = 0;
		bus_wdata = 0;
		cyc(3);
		arst_n = 1;
		cyc(4);
		chk(reset_output_pin, 1);
		reset_input_pin_n = 1;
		cyc(8);
		chk(reset_output_pin, 0);
		chk(fetch_addr, 20'hFFFF0);
		o0 = oc;
		i0 = ic;
		for (int i = 0; i < 16; i++) begin
			a = 20'($random(seed));
			d = 16'($random(seed));
			xfer(1'b1, a, d);
			mem_m[a[7:0]] = d;
			q.push_front(a);
		end
		foreach (q[i]) xfer(1'b0, q[i], 16'h0000);
		chk((ic - i0 < 2 * (oc - o0) + 3) && (ic - i0 > 2 * (oc - o0) - 3), 1);
		hold_req = 1;
		cyc(6);
		chk(hold_ack, 1);
		chk(muxed_addr_data_bus_oe, 0);
		chk(upper_address_pins_oe, 0);
		hold_req = 0;
		nmi_pin = 1;
		cyc(2);
		nmi_pin = 0;
		cyc(4);
		chk(nmi_pending, 1);
		chk(nmi_type, 8'h02);
		nmi_ack = 1;
		cyc(1);
		nmi_ack = 0;
		chk(nmi_pending, 0);
		wait_exec = 1;
		cyc(5);
		chk(wait_stall, 1);
		test_pin_n = 0;
		cyc(5);
		chk(wait_stall, 0);
		wait_exec = 0;
		powerdown_req = 1;
		cyc(5);
		chk(powerdown_active, 1);
		powerdown_req = 0;
		bus_req = 1;
		bus_write = 1;
		bus_addr = q[0];
		cyc(3);
		chk(powerdown_active, 1);
		chk(muxed_addr_data_bus_oe, 0);
		chk(bus_done, 0);
		bus_req = 0;
		bus_write = 0;
		powerdown_timer_pin = 1;
		cyc(6);
		chk(powerdown_active, 0);
		xfer(1'b0, q[0], 16'h0000);
		reset_input_pin_n = 0;
		strap = 0;
		cyc(5);
		reset_input_pin_n = 1;
		cyc(4);
		strap = 1;
		cyc(6);
		chk(on_circuit_float_mode, 1);
		chk(oscillator_drive_pin === 1'b0 || oscillator_drive_pin === 1'b1, 1);
		xfer(1'b1, 20'h00055, 16'hA5A5);
		reset_input_pin_n = 0;
		cyc(5);
		chk(reset_output_pin, 1);
		chk(muxed_addr_data_bus_oe, 0);
		reset_input_pin_n = 1;
		cyc(8);
		chk(on_circuit_float_mode, 0);
		chk(fetch_addr, 20'hFFFF0);
		end_sim;
	end
	initial begin
		#50000;
		bad_count++;
		end_sim;
	end
endmodule // tb_top

bind ccb_core ccb_props chk_i (.*);
